// *** tb.sv ***
// Purpose: self-checking bench for the serial receive path
// Assumes: divisor left at zero, so one sample tick per clock
// Notes: registers reached through axi4-lite read and write tasks
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ****************************************
  // signals
  // ****************************************
  logic aclk; // 250 mhz clock
  logic aresetn; // synchronous reset, low
  logic [31:0] awaddr, wdata, araddr, rdata; // bus payloads
  logic awvalid, awready, wvalid, wready, bvalid, bready; // write side
  logic arvalid, arready, rvalid, rready; // read side
  logic [1:0] bresp, rresp, resp; // responses, last one kept
  logic rx_line; // serial line from the far end
  logic gie; // global interrupt gate
  logic claimed; // receiver owns the pin
  logic irq; // receive complete request
  logic [31:0] rd; // last read value
  int err_total = 0; // mismatches
  int cmp_count = 0; // comparisons
  localparam logic [31:0] A_CTRL = {28'h0, urr_pkg::OFS_CTRL};
  localparam logic [31:0] A_BAUD = {28'h0, urr_pkg::OFS_BAUD};
  localparam logic [31:0] A_STAT = {28'h0, urr_pkg::OFS_STAT};
  localparam logic [31:0] A_DATA = {28'h0, urr_pkg::OFS_DATA};
  localparam logic [31:0] C_ON = 32'h0c3; // enable, irq, 8 bits
  // ****************************************
  // design and far end
  // ****************************************
  urr_receiver urr_receiver_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_rx_pin(rx_line), .global_irq_enable(gie),
    .rx_pin_claimed(claimed), .rx_complete_irq(irq)
  );
  urr_tx_model urr_tx_model_inst (.aclk(aclk), .line(rx_line));
  // ****************************************
  // clock and watchdog
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // cuts a hang short, far above the expected run
  initial begin
    repeat (60000) @(posedge aclk);
    err_total++;
    wrap_up();
  end
  // ****************************************
  // tasks
  // ****************************************
  // compares one value, counts and reports
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one write; bready stays high throughout
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bit aw_d;
    bit w_d;
    int n;
    aw_d = 0;
    w_d = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (bvalid === 1'b1) break;
      if (awready === 1'b1 && !aw_d) begin
        aw_d = 1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_d) begin
        w_d = 1;
        wvalid <= 1'b0;
      end
    end
    resp = bresp;
    if (n == 200) err_total++;
  endtask
  // one read; rready stays high throughout
  task automatic rdr(input logic [31:0] a);
    bit ar_d;
    int n;
    ar_d = 0;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (rvalid === 1'b1) break;
      if (arready === 1'b1 && !ar_d) begin
        ar_d = 1;
        arvalid <= 1'b0;
      end
    end
    rd = rdata;
    resp = rresp;
    if (n == 200) err_total++;
  endtask
  // read and compare
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
  endtask
  // builds a frame; pm 0 none, 1 even, 2 odd; bad flips parity
  task automatic tx(input logic [8:0] d, input int nb, input int pm,
                    input bit bad, input logic stp, input int spb);
    logic [15:0] f;
    logic p;
    int n;
    f = 16'h0000;
    p = pm[1]; // odd parity starts from one
    for (n = 0; n < nb; n++) begin
      f[n + 1] = d[n];
      p = p ^ d[n];
    end
    n = nb + 1;
    if (pm != 0) begin
      f[n] = p ^ bad;
      n++;
    end
    f[n] = stp;
    urr_tx_model_inst.send(f, n + 1, spb, 1'b1);
  endtask
  // prints counts and verdict, ends the run
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    gie = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(claimed, 0);
    rchk(A_CTRL, 32'h0c0);
    rchk(A_BAUD, 32'h0);
    rchk(A_STAT, 32'h0);
    rchk(32'h2, 32'h0);
    chk(resp, 32'h2);
    wr(32'h2, 32'h0);
    chk(resp, 32'h2);
    // noisy character, interrupt gating, read-only flags
    wr(A_CTRL, C_ON);
    chk(resp, 32'h0);
    chk(claimed, 1);
    tx(9'h0a5, 8, 0, 0, 1'b1, 16);
    chk(irq, 1);
    gie <= 1'b0;
    @(posedge aclk);
    chk(irq, 0);
    gie <= 1'b1;
    wr(A_STAT, 32'h0);
    rchk(A_STAT, 32'h1);
    rchk(A_DATA, 32'ha5);
    rchk(A_STAT, 32'h0);
    chk(irq, 0);
    // low stop bit with two-stop setting
    wr(A_CTRL, C_ON | 32'h20);
    tx(9'h03c, 8, 0, 0, 1'b0, 16);
    wr(A_STAT, 32'h0);
    rchk(A_STAT, 32'h3);
    rchk(A_DATA, 32'h3c);
    // eight low samples: only sample 8 votes low, start rejected
    urr_tx_model_inst.spike(8);
    repeat (40) @(posedge aclk);
    rchk(A_STAT, 32'h0);
    // nine low samples: 8 and 9 vote low, start taken, all ones follow
    urr_tx_model_inst.spike(9);
    repeat (200) @(posedge aclk);
    rchk(A_STAT, 32'h1);
    rchk(A_DATA, 32'hff);
    // even and odd, good and bad parity
    for (int t = 0; t < 4; t++) begin
      wr(A_CTRL, C_ON | 32'h08 | (t[0] ? 32'h10 : 32'h0));
      tx(9'h096, 8, 1 + t[0], t[1], 1'b1, 16);
      rchk(A_STAT, {28'h0, t[1], 3'b001});
      rchk(A_STAT, {28'h0, t[1], 3'b001});
      wr(A_CTRL, C_ON);
      rchk(A_STAT, 32'h1);
      rchk(A_DATA, 32'h96);
    end
    // four frames unread: third lost, fourth flagged
    for (int k = 0; k < 4; k++) begin
      tx(9'h010 + 9'(k), 8, 0, 0, 1'b1, 16);
    end
    rchk(A_STAT, 32'h1);
    rchk(A_DATA, 32'h10);
    rchk(A_STAT, 32'h1);
    rchk(A_DATA, 32'h11);
    rchk(A_STAT, 32'h5);
    rchk(A_DATA, 32'h13);
    rchk(A_STAT, 32'h0);
    tx(9'h020, 8, 0, 0, 1'b1, 16);
    rchk(A_STAT, 32'h1);
    rchk(A_DATA, 32'h20);
    // double speed
    wr(A_CTRL, C_ON | 32'h04);
    tx(9'h069, 8, 0, 0, 1'b1, 8);
    rchk(A_STAT, 32'h1);
    rchk(A_DATA, 32'h69);
    // five and nine data bits
    wr(A_CTRL, 32'h003);
    tx(9'h0f5, 5, 0, 0, 1'b1, 16);
    rchk(A_STAT, 32'h1);
    rchk(A_DATA, 32'h15);
    wr(A_CTRL, 32'h1c3);
    tx(9'h1a5, 9, 0, 0, 1'b1, 16);
    rchk(A_STAT, 32'h11);
    rdr(A_DATA);
    chk(rd, 32'ha5);
    // disable flushes a full entry, then aborts a frame
    wr(A_CTRL, C_ON);
    tx(9'h077, 8, 0, 0, 1'b1, 16);
    wr(A_CTRL, 32'h0c2);
    chk(claimed, 0);
    rchk(A_STAT, 32'h0);
    wr(A_CTRL, C_ON);
    fork
      tx(9'h0ff, 8, 0, 0, 1'b1, 16);
      begin
        repeat (60) @(posedge aclk);
        wr(A_CTRL, 32'h0c2);
        wr(A_CTRL, C_ON);
      end
    join
    repeat (20) @(posedge aclk);
    rchk(A_STAT, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire

// *** urr_pkg.sv ***
// Purpose: shared constants for the serial receive path with clock recovery
// Assumes: register byte offsets on a 32-bit AXI4-Lite bus
// Notes: field positions of control and status words are named here
package urr_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [3:0] OFS_CTRL = 4'h0; // control word
  localparam logic [3:0] OFS_BAUD = 4'h4; // sample-clock divisor
  localparam logic [3:0] OFS_STAT = 4'h8; // control_status_a
  localparam logic [3:0] OFS_DATA = 4'hc; // rx_data_register
  // ****************************************
  // control word fields
  // ****************************************
  localparam int CTL_EN = 0; // rx_enable_bit
  localparam int CTL_IE = 1; // rx_complete_irq_enable
  localparam int CTL_U2X = 2; // double_speed_bit
  localparam int CTL_PEN = 3; // parity_enable_bit
  localparam int CTL_POD = 4; // parity_type_select
  localparam int CTL_SBS = 5; // stop_bit_count_select, no effect here
  localparam int CTL_SZ = 6; // character size code, 3 bits
  localparam int CTL_W = 9; // width of control word
  localparam logic [8:0] CTL_RST = 9'h0c0; // 8 data bits, all off
  localparam logic [11:0] BAUD_RST = 12'h000; // tick every cycle
  // ****************************************
  // status word fields
  // ****************************************
  localparam int ST_RXC = 0; // rx_complete_flag
  localparam int ST_FE = 1; // frame_error_flag
  localparam int ST_DOR = 2; // data_overrun_flag
  localparam int ST_PE = 3; // parity_error_flag
  localparam int ST_B8 = 4; // ninth data bit
  // ****************************************
  // sampling
  // ****************************************
  localparam logic [4:0] SPB_NORM = 5'h10; // samples per bit, normal
  localparam logic [4:0] SPB_DBL = 5'h08; // samples per bit, double speed
  localparam logic [4:0] VOTE_NORM = 5'h08; // first centre sample, normal
  localparam logic [4:0] VOTE_DBL = 5'h04; // first centre sample, double
  localparam logic [4:0] SMP_FIRST = 5'h01; // first low sample of start
  localparam logic [1:0] RESP_OK = 2'h0; // axi okay
  localparam logic [1:0] RESP_ERR = 2'h2; // axi slave error
  // receive state, one-hot
  typedef enum logic [3:0] {
    RS_IDLE = 4'b0001,
    RS_START = 4'b0010,
    RS_DATA = 4'b0100,
    RS_STOP = 4'b1000
  } urr_state_t;
endpackage

// *** urr_receiver.sv ***
// Purpose: asynchronous receive path with two-entry status-carrying buffer
// Assumes: serial_rx_pin synchronous to aclk; single 250 MHz clock
// Notes: registers reached over AXI4-Lite, one aligned word each
`timescale 1ns/10ps
`default_nettype none
// Operation
// - complete flag high while buffer holds data
// - clearing enable flushes buffer
// - interrupt requested while flag and enables set
// - error flags stored with each character
// - error flags read-only, raise no interrupt
// - frame error follows first stop bit only
// - overrun when full, waiting, new start
// - overrun cleared on successful transfer
// - parity error zero while checking disabled
// - parity checked per type, stored
// - parity error valid until data read; here it reads zero once checking is switched off
// - disable stops reception, releases pin
// - sixteen samples per bit, eight doubled
// - start bit voted, rejected if high
// - first low sample is sample one
// - resynchronise on every start bit
// - recovery machine sixteen or eight states
// - each bit by three-sample majority
// - frame ends at first stop bit
// - finished frame moves into buffer
// - unused upper data bits read zero
// - stop bit voted, low sets frame error
module urr_receiver (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_rx_pin,
  input wire logic global_irq_enable,
  output logic rx_pin_claimed,
  output logic rx_complete_irq
);
  // ****************************************
  // functions
  // ****************************************
  // two-of-three majority
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction
  // data bits from size code: 0..3 give 5..8, 7 gives 9
  function automatic logic [3:0] nbits(input logic [2:0] sz);
    if (sz == 3'h7) begin
      nbits = 4'h9;
    end else if (sz[2]) begin
      nbits = 4'h8;
    end else begin
      nbits = 4'h5 + {2'h0, sz[1:0]};
    end
  endfunction

  // ****************************************
  // registers and state
  // ****************************************
  logic [8:0] ctl_q; // control word
  logic [11:0] baud_q; // divisor
  logic [11:0] div_q; // divider count
  logic tick; // one-cycle sample enable
  urr_pkg::urr_state_t st_q; // recovery state
  logic [4:0] smp_q; // sample number inside bit
  logic [3:0] bit_q; // data/parity bit index
  logic [1:0] vote_q; // first two centre samples
  logic prev_q; // previous sample, for edge search
  logic [8:0] shr_q; // receive shift register
  logic par_q; // received parity bit
  logic pend_q; // frame waiting in shift register
  logic [8:0] pend_dat_q; // waiting character
  logic pend_fe_q; // waiting frame error
  logic pend_pe_q; // waiting parity error
  logic dor_q; // overrun to attach to next transfer
  logic [11:0] fifo_q [2]; // {b8, pe, dor, fe, data}
  logic wp_q; // write pointer
  logic rp_q; // read pointer
  logic [1:0] cnt_q; // entries held
  logic en; // receiver enabled
  logic u2x; // double speed
  logic pen; // parity checking on
  logic [4:0] spb; // samples per bit
  logic [4:0] vfirst; // first centre sample
  logic at_vote; // last centre sample this tick
  logic bitval; // voted bit value
  logic fall; // falling edge seen this tick
  logic full; // buffer holds two
  logic push; // transfer into buffer
  logic pop; // data register read
  logic [3:0] nd; // data bits per frame
  logic [11:0] head; // oldest entry
  logic rxc; // rx_complete_flag

  assign en = ctl_q[urr_pkg::CTL_EN];
  assign u2x = ctl_q[urr_pkg::CTL_U2X];
  assign pen = ctl_q[urr_pkg::CTL_PEN];
  assign nd = nbits(ctl_q[urr_pkg::CTL_SZ +: 3]);
  // sample rate per mode
  assign spb = u2x ? urr_pkg::SPB_DBL : urr_pkg::SPB_NORM;
  assign vfirst = u2x ? urr_pkg::VOTE_DBL : urr_pkg::VOTE_NORM;
  assign at_vote = tick && (smp_q == vfirst + 5'h02);
  // three centre samples voted
  assign bitval = maj3({vote_q, serial_rx_pin});
  assign fall = tick && prev_q && !serial_rx_pin;
  assign full = cnt_q[1];
  assign rxc = (cnt_q != 2'h0);
  assign head = fifo_q[rp_q];
  assign push = pend_q && !full;
  // pin handed back while disabled
  assign rx_pin_claimed = en;
  // level request, no error source feeds it
  assign rx_complete_irq = rxc && ctl_q[urr_pkg::CTL_IE] &&
                           global_irq_enable;

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic aw_q; // address held
  logic w_q; // data held
  logic [3:0] awa_q; // held write offset
  logic [31:0] wd_q; // held write data
  logic [3:0] ws_q; // held strobes
  logic wr_go; // both halves present
  logic ar_hs; // read address taken
  logic [3:0] ara; // read offset

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign ara = s_axi_araddr[3:0];
  // reading data register advances buffer
  assign pop = ar_hs && (ara == urr_pkg::OFS_DATA) && rxc;

  // write channel capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 4'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr[3:0];
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  // write response and register update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= urr_pkg::RESP_OK;
      ctl_q <= urr_pkg::CTL_RST;
      baud_q <= urr_pkg::BAUD_RST;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= urr_pkg::RESP_OK;
        case (awa_q)
          urr_pkg::OFS_CTRL: begin
            if (ws_q[0]) begin
              ctl_q[7:0] <= wd_q[7:0];
            end
            if (ws_q[1]) begin
              ctl_q[8] <= wd_q[8];
            end
          end
          urr_pkg::OFS_BAUD: begin
            if (ws_q[0]) begin
              baud_q[7:0] <= wd_q[7:0];
            end
            if (ws_q[1]) begin
              baud_q[11:8] <= wd_q[11:8];
            end
          end
          // status flags ignore writes
          urr_pkg::OFS_STAT: ;
          urr_pkg::OFS_DATA: ;
          default: s_axi_bresp <= urr_pkg::RESP_ERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel, data sampled at address accept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= urr_pkg::RESP_OK;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= urr_pkg::RESP_OK;
      s_axi_rdata <= 32'h0;
      case (ara)
        urr_pkg::OFS_CTRL: s_axi_rdata[8:0] <= ctl_q;
        urr_pkg::OFS_BAUD: s_axi_rdata[11:0] <= baud_q;
        urr_pkg::OFS_STAT: begin
          s_axi_rdata[urr_pkg::ST_RXC] <= rxc;
          s_axi_rdata[urr_pkg::ST_FE] <= rxc && head[8];
          s_axi_rdata[urr_pkg::ST_DOR] <= rxc && head[9];
          // masked while checking is off
          s_axi_rdata[urr_pkg::ST_PE] <= rxc && head[10] && pen;
          s_axi_rdata[urr_pkg::ST_B8] <= rxc && head[11];
        end
        // upper bits already zero from the shift register
        urr_pkg::OFS_DATA: s_axi_rdata[7:0] <= rxc ? head[7:0] : 8'h00;
        default: s_axi_rresp <= urr_pkg::RESP_ERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // sample clock divider
  // ****************************************
  // one-cycle tick every baud_q+1 cycles
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      div_q <= 12'h000;
    end else if (div_q >= baud_q) begin
      div_q <= 12'h000;
    end else begin
      div_q <= div_q + 12'h001;
    end
  end
  assign tick = en && (div_q >= baud_q);

  // ****************************************
  // clock and data recovery
  // ****************************************
  // state machine, dropped at once on disable
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      st_q <= urr_pkg::RS_IDLE;
      smp_q <= 5'h00;
      bit_q <= 4'h0;
      vote_q <= 2'h0;
      prev_q <= 1'b0;
      shr_q <= 9'h000;
      par_q <= 1'b0;
    end else if (tick) begin
      prev_q <= serial_rx_pin;
      // collect the centre samples
      if (smp_q == vfirst || smp_q == vfirst + 5'h01) begin
        vote_q <= {vote_q[0], serial_rx_pin};
      end
      case (st_q)
        urr_pkg::RS_IDLE: begin
          // a falling edge seen in idle restarts bit timing
          if (fall) begin
            st_q <= urr_pkg::RS_START;
            // this tick was sample one, so the next one is two
            smp_q <= urr_pkg::SMP_FIRST + 5'h01;
            bit_q <= 4'h0;
            shr_q <= 9'h000;
          end
        end
        urr_pkg::RS_START: begin
          if (at_vote && bitval) begin
            st_q <= urr_pkg::RS_IDLE; // noise spike
            prev_q <= 1'b0;
          end else if (smp_q == spb) begin
            st_q <= urr_pkg::RS_DATA;
            smp_q <= urr_pkg::SMP_FIRST;
          end else begin
            smp_q <= smp_q + 5'h01;
          end
        end
        urr_pkg::RS_DATA: begin
          if (at_vote) begin
            if (bit_q < nd) begin
              shr_q[bit_q] <= bitval;
            end else begin
              par_q <= bitval;
            end
          end
          if (smp_q == spb) begin
            smp_q <= urr_pkg::SMP_FIRST;
            if (bit_q == nd - {3'h0, !pen}) begin
              st_q <= urr_pkg::RS_STOP;
            end else begin
              bit_q <= bit_q + 4'h1;
            end
          end else begin
            smp_q <= smp_q + 5'h01;
          end
        end
        urr_pkg::RS_STOP: begin
          // frame ends at first stop vote
          if (at_vote) begin
            st_q <= urr_pkg::RS_IDLE;
          end else begin
            smp_q <= smp_q + 5'h01;
          end
        end
        default: st_q <= urr_pkg::RS_IDLE;
      endcase
    end
  end

  // ****************************************
  // shift-register hold and overrun
  // ****************************************
  logic done; // first stop bit voted
  assign done = (st_q == urr_pkg::RS_STOP) && at_vote;

  // waiting frame and its flags
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      pend_q <= 1'b0;
      pend_dat_q <= 9'h000;
      pend_fe_q <= 1'b0;
      pend_pe_q <= 1'b0;
      dor_q <= 1'b0;
    end else begin
      if (done) begin
        pend_q <= 1'b1;
        pend_dat_q <= shr_q;
        pend_fe_q <= !bitval;
        // even at type zero, odd at one
        pend_pe_q <= pen && (^shr_q ^ par_q ^ ctl_q[urr_pkg::CTL_POD]);
      end else if (push) begin
        pend_q <= 1'b0;
      end
      // new start overwrites the waiting frame
      if (st_q == urr_pkg::RS_IDLE && fall && pend_q && full) begin
        dor_q <= 1'b1;
        pend_q <= 1'b0;
      end else if (push) begin
        dor_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // two-entry receive buffer
  // ****************************************
  // pointers and fill, flushed on disable
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= !wp_q;
      end
      if (pop) begin
        rp_q <= !rp_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end

  // entry storage with flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_q[0] <= 12'h000;
      fifo_q[1] <= 12'h000;
    end else if (push) begin
      fifo_q[wp_q] <= {pend_dat_q[8], pend_pe_q, dor_q, pend_fe_q,
                       pend_dat_q[7:0]};
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // start bit voted high at its last centre sample
  sequence s_start_vote_high;
    st_q == urr_pkg::RS_START && at_vote && bitval;
  endsequence
  // new start while buffer full and frame waiting
  sequence s_overrun_cause;
    en && st_q == urr_pkg::RS_IDLE && fall && pend_q && full;
  endsequence

  AST_RXC_DROP: assert property (
    cnt_q == 2'h1 && pop && !push |=> !rxc
  ) else $error("complete flag stays high on empty buffer");
  AST_FLUSH: assert property (
    !en |=> cnt_q == 2'h0 && !rxc && !pend_q
  ) else $error("buffer not flushed on disable");
  AST_IRQ: assert property (
    rx_complete_irq == (rxc && ctl_q[urr_pkg::CTL_IE] && global_irq_enable)
  ) else $error("interrupt request wrong");
  AST_PE_OFF: assert property (
    ar_hs && ara == urr_pkg::OFS_STAT && !pen
      |=> !s_axi_rdata[urr_pkg::ST_PE]
  ) else $error("parity error shown while checking off");
  AST_REJECT: assert property (
    en ##0 s_start_vote_high |=> st_q == urr_pkg::RS_IDLE
  ) else $error("noisy start bit accepted");
  AST_SMP_RANGE: assert property (
    st_q != urr_pkg::RS_IDLE |-> smp_q >= 5'h01 && smp_q <= spb
  ) else $error("sample number out of range");
  AST_OVERRUN: assert property (
    s_overrun_cause |=> dor_q && !pend_q
  ) else $error("overrun not flagged");
  AST_DOR_CLR: assert property (
    push |=> !dor_q ##0 fifo_q[$past(wp_q)][9] == $past(dor_q)
  ) else $error("overrun not handed to buffer and cleared");
  AST_STOP_MOVE: assert property (
    en && done && !full && !pop |=> pend_q ##1 (cnt_q != 2'h0 || !en)
  ) else $error("frame not moved into buffer");
  AST_DISABLE: assert property (
    !en |-> !rx_pin_claimed ##1 st_q == urr_pkg::RS_IDLE
  ) else $error("reception continues while disabled");
endmodule
`default_nettype wire

// *** urr_tx_model.sv ***
// Purpose: far-end serial transmitter driving the receive line
// Assumes: one sample tick per aclk, so each line cell lasts spb clocks
// Notes: line rests high between frames, as a pulled-up line would
`timescale 1ns/10ps
`default_nettype none
module urr_tx_model (
  input wire logic aclk,
  output logic line
);
  // ****************************************
  // frame shifter
  // ****************************************
  // idle level before the first frame
  initial line = 1'b1;
  // shifts n cells of f out lsb first, spb ticks per cell
  task automatic send(input logic [15:0] f, input int n, input int spb,
                      input bit noise);
    for (int i = 0; i < n; i++) begin
      for (int s = 0; s < spb; s++) begin
        @(posedge aclk);
        // one upset sample on the first centre sample of every cell
        line <= (noise && s == spb / 2 - 1) ? ~f[i] : f[i];
      end
    end
    @(posedge aclk);
    line <= 1'b1; // release to idle
  endtask
  // short low pulse, shorter than a start bit
  task automatic spike(input int len);
    @(posedge aclk);
    line <= 1'b0;
    repeat (len) @(posedge aclk);
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire
